// [rtl/lcr_pkg.sv]
// Shared constants, field layout and types of the logic cell block.
package lcr_pkg;

    // Register bus data width and responses.
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Register byte offsets.
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] LUT_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;

    // Stored widths and reset values.
    localparam int CFG_W = 16;
    localparam int LUT_W = 16;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] LUT_RESET = 16'h0000;

    // Configuration register field positions.
    localparam int FF_LSB = 0;
    localparam int MODE_LSB = 2;
    localparam int LOCAL_SEL_BIT = 4;
    localparam int ROUTE_SEL_BIT = 5;
    localparam int CLR_EN_BIT = 6;
    localparam int CLR_SEL_LSB = 7;
    localparam int PRE_EN_BIT = 9;
    localparam int PRE_SEL_LSB = 10;
    localparam int CLK_SEL_LSB = 12;
    localparam int ALOAD_BIT = 14;
    localparam int CASC_EN_BIT = 15;

    // Status register bit positions.
    localparam int STAT_Q_BIT = 0;
    localparam int STAT_LOCAL_BIT = 1;
    localparam int STAT_ROUTE_BIT = 2;
    localparam int STAT_CARRY_BIT = 3;
    localparam int STAT_CASC_BIT = 4;
    localparam int STAT_TBUS_BIT = 5;

    // Cells chained inside one cluster.
    localparam int CLUSTER_CELLS = 8;

    // Storage element behaviour.
    typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} lcr_ff_t;

    // Operating mode of the cell.
    typedef enum logic [1:0] {MODE_NORMAL, MODE_ARITH, MODE_UPDOWN, MODE_CLEAR} lcr_mode_t;

endpackage

// [rtl/lcr_cell.sv]
// One programmable logic cell with its register, chains and tri-state emulation.
//
// Overview of operation
// - Register acts as D, T, JK or SR.
// - Bypass register so the lookup drives an output through the output stage.
// - Two outputs, local and long-distance, independently selected.
// - Lookup and register may drive different outputs.
// - Carry-in feeds lookup and next carry stage.
// - Long carry chains link clusters, eight per cluster.
// - Cluster-crossing carry hops to alternate clusters.
// - Carry chain restarts past the memory block.
// - Chains link cells; cascade ANDs wide functions.
// - Counter has enable, direction, load, clock enable.
// - Counter splits lookup into two three-input tables.
// - Two-input selector provides synchronous counter load.
// - Clear and preset load register asynchronously.
// - Clearable counter takes clear from cascade-in.
// - Load selector output ANDed with inverted clear.
// - Bus emulation: contention low, no driver high.
// - Clear and preset come from control inputs.
// - Clear selectable from either cluster control line.
// - Control one loads fourth input when configured.
// - Clock, clear, preset sources are selectable.
`timescale 1ns/10ps
module lcr_cell #(
    parameter int CELL_INDEX = 0,
    parameter int CLUSTER_INDEX = 0,
    parameter int MEM_CLUSTER = 4,
    parameter int TBUS_W = 4,
    parameter int ADDR_W = 8
) (
    input logic core_clk, // Block clock.
    input logic reset_n, // Asynchronous reset, active low.
    input logic clk_en, // Freezes all state while low.
    input logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    input logic [lcr_pkg::DATA_W-1:0] s_axi_wdata, // Write data.
    input logic [3:0] s_axi_wstrb, // Write byte enables.
    output logic s_axi_bvalid, // Write response valid.
    input logic s_axi_bready, // Write response ready.
    output logic [1:0] s_axi_bresp, // Write response code.
    input logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    input logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    output logic s_axi_rvalid, // Read data valid.
    input logic s_axi_rready, // Read data ready.
    output logic [lcr_pkg::DATA_W-1:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response code.
    input logic [2:0] data_in, // Lower three data inputs.
    input logic fourth_data_input, // Fourth data input.
    input logic cluster_control_one, // Cluster control line one.
    input logic cluster_control_two, // Cluster control line two.
    input logic global_clear, // Clear from a global line.
    input logic pin_clear, // Clear from an input pin.
    input logic global_preset, // Preset from a global line.
    input logic pin_preset, // Preset from an input pin.
    input logic global_clk_tick, // Register clock from a global line.
    input logic pin_clk_tick, // Register clock from an input pin.
    input logic internal_clk_tick, // Register clock from internal logic.
    input logic carry_in, // Carry from the lower cell in the cluster.
    input logic carry_hop_in, // Carry from the cluster two places back.
    input logic cascade_in, // Cascade from the previous cell.
    input logic cascade_hop_in, // Cascade from the previous cluster.
    input logic [TBUS_W-1:0] tbus_data, // Emulated bus driver data.
    input logic [TBUS_W-1:0] tbus_oe, // Emulated bus driver enables.
    output logic local_out, // Output to local cluster routing.
    output logic route_out, // Output to row or column routing.
    output logic carry_out, // Carry to the next higher cell.
    output logic cascade_out, // Cascade to the next cell.
    output logic tbus_out // Resolved emulated bus level.
);
    import lcr_pkg::*;

    // Parameter values the structure cannot serve are refused.
    if (CELL_INDEX < 0 || CELL_INDEX >= CLUSTER_CELLS) begin : g_bad_cell
        $error("CELL_INDEX outside the cluster");
    end
    if (CLUSTER_INDEX < 0 || MEM_CLUSTER < 2 || TBUS_W < 1 || ADDR_W < 4) begin : g_bad_par
        $error("cluster, bus or address parameter out of range");
    end

    // The first cell of a cluster takes its chains from further away.
    localparam bit FIRST_CELL = (CELL_INDEX == 0);
    localparam bit CARRY_START = (CLUSTER_INDEX < 2) || (CLUSTER_INDEX == MEM_CLUSTER)
        || (CLUSTER_INDEX == MEM_CLUSTER + 1);
    localparam bit CASC_START = (CLUSTER_INDEX == 0) || (CLUSTER_INDEX == MEM_CLUSTER);

    logic [CFG_W-1:0] cfg;
    logic [LUT_W-1:0] lut_table;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata, wr_word, stat_word;
    logic [3:0] wstrb;
    lcr_ff_t ff_mode;
    lcr_mode_t mode;
    logic q, next_q, aw_got, w_got, counting, carry_eff, cascade_eff, dir;
    logic lut_res, lut_carry, cnt_val, load_val, core_next, tick;
    logic clr_act, ald_act, pre_act, next_local, next_route, next_tbus;

    // Selects one of four sources for the register's clock, clear or preset.
    function automatic logic pick(input logic [1:0] sel, input logic [3:0] src);
        return src[sel];
    endfunction

    // Next value of the storage element; b is the K or R input.
    function automatic logic ff_next(input lcr_ff_t f, input logic cur, input logic a,
                                     input logic b);
        case (f)
            FF_D: ff_next = a;
            FF_T: ff_next = cur ^ a;
            FF_JK: ff_next = (a & ~cur) | (~b & cur);
            FF_SR: ff_next = b ? 1'b0 : (a ? 1'b1 : cur);
            default: ff_next = cur;
        endcase
    endfunction

    // True when a word address matches a register offset.
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
        return {addr[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs);
    endfunction

    // Register read view, also the base that byte enables merge into.
    function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] addr);
        reg_read = '0;
        if (hit(addr, CFG_OFS)) begin
            reg_read = {16'h0000, cfg};
        end else if (hit(addr, LUT_OFS)) begin
            reg_read = {16'h0000, lut_table};
        end else if (hit(addr, STAT_OFS)) begin
            reg_read = stat_word;
        end
    endfunction

    // Configuration fields that steer the cell.
    assign ff_mode = lcr_ff_t'(cfg[FF_LSB +: 2]);
    assign mode = lcr_mode_t'(cfg[MODE_LSB +: 2]);
    assign counting = (mode == MODE_UPDOWN) || (mode == MODE_CLEAR);

    // Chain entry: a carry hop skips one cluster so both parities fill in turn.
    assign carry_eff = FIRST_CELL ? (CARRY_START ? 1'b0 : carry_hop_in) : carry_in;
    assign cascade_eff = FIRST_CELL ? (CASC_START ? (mode != MODE_CLEAR) : cascade_hop_in)
        : cascade_in;

    // Lookup: one four-input table, or two three-input halves for arithmetic.
    always_comb begin
        dir = (mode == MODE_UPDOWN) ? data_in[0] : 1'b1;
        case (mode)
            MODE_NORMAL: begin
                lut_res = lut_table[{fourth_data_input, data_in}];
                lut_carry = carry_eff;
            end
            MODE_ARITH: begin
                lut_res = lut_table[{1'b0, carry_eff, data_in[1:0]}];
                lut_carry = lut_table[{1'b1, carry_eff, data_in[1:0]}];
            end
            default: begin
                lut_res = lut_table[{1'b0, dir, carry_eff, q}];
                lut_carry = lut_table[{1'b1, dir, carry_eff, q}];
            end
        endcase
    end

    // Counter path: enable, load selector, then the clearable AND stage.
    always_comb begin
        cnt_val = data_in[1] ? lut_res : q;
        load_val = data_in[2] ? fourth_data_input : cnt_val;
        if (mode == MODE_CLEAR) begin
            load_val = load_val & ~cascade_eff;
        end
        core_next = counting ? load_val : ff_next(ff_mode, q, lut_res, fourth_data_input);
    end

    // Register controls; inputs are synchronous, so async means no wait for the tick.
    assign tick = pick(cfg[CLK_SEL_LSB +: 2],
        {pin_clk_tick, global_clk_tick, internal_clk_tick, 1'b1});
    assign clr_act = cfg[CLR_EN_BIT] & pick(cfg[CLR_SEL_LSB +: 2],
        {pin_clear, global_clear, cluster_control_two, cluster_control_one});
    assign pre_act = cfg[PRE_EN_BIT] & pick(cfg[PRE_SEL_LSB +: 2],
        {pin_preset, global_preset, cluster_control_two, cluster_control_one});
    assign ald_act = cfg[ALOAD_BIT] & cluster_control_one;

    // Clear first, then load, then preset, and only then the clock.
    always_comb begin
        if (clr_act) begin
            next_q = 1'b0;
        end else if (ald_act) begin
            next_q = fourth_data_input;
        end else if (pre_act) begin
            next_q = 1'b1;
        end else if (tick) begin
            next_q = core_next;
        end else begin
            next_q = q;
        end
        next_local = cfg[LOCAL_SEL_BIT] ? next_q : lut_res;
        next_route = cfg[ROUTE_SEL_BIT] ? next_q : lut_res;
    end

    // Bus emulation: a one-hot enable passes its data, otherwise a fixed level.
    always_comb begin
        if (tbus_oe == '0) begin
            next_tbus = 1'b1;
        end else if ((tbus_oe & (tbus_oe - 1'b1)) != '0) begin
            next_tbus = 1'b0;
        end else begin
            next_tbus = |(tbus_oe & tbus_data);
        end
    end

    // Storage element of the cell.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= 1'b0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    // Registered cell outputs; the register path adds no extra stage.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            local_out <= 1'b0;
            route_out <= 1'b0;
            carry_out <= 1'b0;
            cascade_out <= 1'b0;
            tbus_out <= 1'b1;
        end else if (clk_en) begin
            local_out <= next_local;
            route_out <= next_route;
            carry_out <= lut_carry;
            cascade_out <= (cfg[CASC_EN_BIT] && !counting) ? (lut_res & cascade_eff) : lut_res;
            tbus_out <= next_tbus;
        end
    end

    // Status view of the cell's own state.
    always_comb begin
        stat_word = '0;
        stat_word[STAT_Q_BIT] = q;
        stat_word[STAT_LOCAL_BIT] = local_out;
        stat_word[STAT_ROUTE_BIT] = route_out;
        stat_word[STAT_CARRY_BIT] = carry_out;
        stat_word[STAT_CASC_BIT] = cascade_out;
        stat_word[STAT_TBUS_BIT] = tbus_out;
        wr_word = reg_read(waddr);
        for (int i = 0; i < 4; i++) begin
            if (wstrb[i]) begin
                wr_word[8*i +: 8] = wdata[8*i +: 8];
            end
        end
    end

    // Write channel: address and data in either order, then the answer.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            waddr <= '0;
            wdata <= '0;
            wstrb <= 4'h0;
            cfg <= CFG_RESET;
            lut_table <= LUT_RESET;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr <= s_axi_awaddr;
                aw_got <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata <= s_axi_wdata;
                wstrb <= s_axi_wstrb;
                w_got <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                if (hit(waddr, CFG_OFS)) begin
                    cfg <= wr_word[CFG_W-1:0];
                end else if (hit(waddr, LUT_OFS)) begin
                    lut_table <= wr_word[LUT_W-1:0];
                end else if (!hit(waddr, STAT_OFS)) begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: one read in flight, data one edge after the address.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= reg_read(s_axi_araddr);
                s_axi_rresp <= (hit(s_axi_araddr, CFG_OFS) || hit(s_axi_araddr, LUT_OFS)
                    || hit(s_axi_araddr, STAT_OFS)) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Checks on the cell's behaviour, sampled on the block clock.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_bus_idle;
        clk_en && tbus_oe == '0 |=> tbus_out;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("idle bus not high");
    property p_bus_fight;
        clk_en && $countones(tbus_oe) > 1 |=> !tbus_out;
    endproperty
    a_bus_fight: assert property (p_bus_fight) else $error("contended bus not low");
    property p_clear_first;
        clk_en && clr_act |=> !q && !(route_out && $past(cfg[ROUTE_SEL_BIT]));
    endproperty
    a_clear_first: assert property (p_clear_first) else $error("clear lost");
    property p_aload;
        clk_en && !clr_act && ald_act |=> q == $past(fourth_data_input);
    endproperty
    a_aload: assert property (p_aload) else $error("async load wrong");
    property p_toggle;
        clk_en && !clr_act && !ald_act && !pre_act && tick && !counting && ff_mode == FF_T
        |=> q == ($past(q) ^ $past(lut_res));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle wrong");
    property p_bypass;
        clk_en && !cfg[LOCAL_SEL_BIT] |=> local_out == $past(lut_res);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass wrong");
    property p_packed;
        clk_en && cfg[ROUTE_SEL_BIT] |=> route_out == q;
    endproperty
    a_packed: assert property (p_packed) else $error("register output wrong");
    property p_sync_clear;
        clk_en && mode == MODE_CLEAR && cascade_eff && tick && !clr_act && !ald_act && !pre_act
        |=> !q;
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("sync clear lost");
    property p_sync_load;
        clk_en && counting && data_in[2] && tick && !clr_act && !ald_act && !pre_act
        && !(mode == MODE_CLEAR && cascade_eff) |=> q == $past(fourth_data_input);
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("sync load wrong");

endmodule

// [bench/lcr_neighbour.sv]
// Model of the lower-order neighbouring cell that feeds the chain inputs.
`timescale 1ns/10ps
module lcr_neighbour (
    input wire logic core_clk, // Block clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic next_carry, // Carry the lower cell computes.
    input wire logic next_cascade, // Cascade the lower cell computes.
    output logic carry_q, // Registered carry toward the cell.
    output logic cascade_q, // Registered cascade toward the cell.
    output logic carry_hop_q // Hop carry from an unlinked cluster.
);
    // A real cell registers its chain outputs, so the model adds one edge of lag.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            carry_q <= 1'b0;
            cascade_q <= 1'b1;
        end else begin
            carry_q <= next_carry;
            cascade_q <= next_cascade;
        end
    end
    // The hop path is unlinked here; it moves to expose any leakage.
    assign carry_hop_q = ~carry_q;
endmodule

// [bench/tb.sv]
// Self-checking testbench for one logic cell over its register bus and cell pins.
`timescale 1ns/10ps
module tb;
    import lcr_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [2:0] data_in = 3'h0;
    logic fourth_data_input = 1'b0, cluster_control_one = 1'b0, cluster_control_two = 1'b0;
    logic global_clear = 1'b0, pin_clear = 1'b0, global_preset = 1'b0, pin_preset = 1'b0;
    logic global_clk_tick = 1'b0, pin_clk_tick = 1'b0, internal_clk_tick = 1'b0;
    logic next_carry = 1'b0, next_cascade = 1'b0, cascade_hop_in = 1'b1;
    logic carry_in, carry_hop_in, cascade_in, q_prev;
    logic [3:0] tbus_data = 4'h0, tbus_oe = 4'h0;
    logic local_out, route_out, carry_out, cascade_out, tbus_out;
    logic [8:0] bus_case [4] = '{{4'h0, 4'hf, 1'b1}, {4'h2, 4'h0, 1'b0},
                                 {4'h4, 4'h4, 1'b1}, {4'h3, 4'h3, 1'b0}};
    int n_mismatch = 0;
    int samples_checked = 0;

    // Free-running block clock.
    always #2 core_clk = ~core_clk;

    lcr_cell #(.CELL_INDEX(1), .CLUSTER_INDEX(1)) uut (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .data_in(data_in),
        .fourth_data_input(fourth_data_input), .cluster_control_one(cluster_control_one),
        .cluster_control_two(cluster_control_two), .global_clear(global_clear),
        .pin_clear(pin_clear), .global_preset(global_preset), .pin_preset(pin_preset),
        .global_clk_tick(global_clk_tick), .pin_clk_tick(pin_clk_tick),
        .internal_clk_tick(internal_clk_tick), .carry_in(carry_in), .carry_hop_in(carry_hop_in),
        .cascade_in(cascade_in), .cascade_hop_in(cascade_hop_in), .tbus_data(tbus_data),
        .tbus_oe(tbus_oe), .local_out(local_out), .route_out(route_out), .carry_out(carry_out),
        .cascade_out(cascade_out), .tbus_out(tbus_out));

    lcr_neighbour lower (.core_clk(core_clk), .reset_n(reset_n), .next_carry(next_carry),
        .next_cascade(next_cascade), .carry_q(carry_in), .cascade_q(cascade_in),
        .carry_hop_q(carry_hop_in));

    // Compare one value and count it.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Wait some edges, then step past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Offer address and data together; release each when taken.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read one word; data and response are taken where rvalid is seen.
    task automatic axi_read(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Raise the chosen clear and preset lines for one sampling edge.
    task automatic pulse(input logic [3:0] clr, input logic [3:0] pre);
        @(posedge core_clk);
        {pin_clear, global_clear} <= clr[3:2];
        {pin_preset, global_preset} <= pre[3:2];
        {cluster_control_two, cluster_control_one} <= clr[1:0] | pre[1:0];
        @(posedge core_clk);
        {pin_clear, global_clear, pin_preset, global_preset} <= 4'h0;
        {cluster_control_two, cluster_control_one} <= 2'b00;
        #1;
    endtask

    // Print the counts and the verdict, then end the run.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A hang is cut short far beyond the few hundred cycles needed.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end

    // Main sequence: registers first, then bypass, chains, packing, clocks, toggle, controls, counters, arithmetic and bus.
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        axi_read(CFG_OFS);
        check("cfg reset", rd, CFG_RESET);
        axi_read(LUT_OFS);
        check("lut reset", rd, LUT_RESET);
        axi_write(LUT_OFS, 32'hffff_8000);
        axi_read(LUT_OFS);
        check("lut width", rd, 32'h0000_8000);
        axi_read(8'h0c);
        check("unmapped read", resp, RESP_SLVERR);
        axi_write(8'h10, 32'h0000_ffff);
        check("unmapped write", resp, RESP_SLVERR);
        axi_write(STAT_OFS, 32'h0000_0000);
        check("status write", resp, RESP_OKAY);
        axi_read(STAT_OFS);
        check("status", rd & 32'h0000_0027, 32'h0000_0020);
        // Bypass path: lookup result reaches the local output one edge later.
        @(posedge core_clk);
        data_in <= 3'h7;
        fourth_data_input <= 1'b1;
        tick(1);
        check("bypass high", local_out, 1'b1);
        @(posedge core_clk);
        data_in <= 3'h3;
        tick(1);
        check("bypass low", local_out, 1'b0);
        // Chains from the lower cell: carry passes, cascade is ANDed in.
        axi_write(CFG_OFS, 32'h0000_8000);
        @(posedge core_clk);
        data_in <= 3'h7;
        for (int v = 1; v >= 0; v--) begin
            @(posedge core_clk);
            next_carry <= v[0];
            next_cascade <= v[0];
            tick(2);
            check("carry forward", carry_out, v[0]);
            check("cascade and", cascade_out, v[0]);
        end
        // Register packing: lookup on local, held register on route.
        axi_write(CFG_OFS, 32'h0000_0020);
        tick(1);
        check("route reg", route_out, 1'b1);
        axi_write(CFG_OFS, 32'h0000_1020);
        @(posedge core_clk);
        data_in <= 3'h0;
        tick(1);
        check("local lut", local_out, 1'b0);
        check("route held", route_out, 1'b1);
        // Each of the internal, global and pin clock sources gates the register: held without its tick.
        for (int s = 1; s <= 3; s++) begin
            axi_write(CFG_OFS, 32'h0000_0020 | (s << 12));
            @(posedge core_clk);
            data_in <= (s == 2) ? 3'h7 : 3'h0;
            fourth_data_input <= (s == 2);
            tick(2);
            check("no tick", route_out, s != 2);
            @(posedge core_clk);
            {pin_clk_tick, global_clk_tick, internal_clk_tick} <= 3'b001 << (s - 1);
            @(posedge core_clk);
            {pin_clk_tick, global_clk_tick, internal_clk_tick} <= 3'b000;
            #1;
            check("tick", route_out, s == 2);
        end
        // Toggle behaviour with an all-ones lookup and a free clock.
        axi_write(LUT_OFS, 32'h0000_ffff);
        axi_write(CFG_OFS, 32'h0000_0021);
        tick(1);
        q_prev = route_out;
        tick(1);
        check("toggle", route_out, !q_prev);
        // Every clear and preset source, with the clock tick held low.
        for (int s = 0; s < 4; s++) begin
            axi_write(CFG_OFS, 32'h0000_1260 | (s << 7) | (((s + 1) % 4) << 10));
            pulse(4'h0, 4'h1 << ((s + 1) % 4));
            check("preset", route_out, 1'b1);
            pulse(4'h1 << s, 4'h0);
            check("clear", route_out, 1'b0);
        end
        // Load from control one, then clear and load together.
        axi_write(CFG_OFS, 32'h0000_50e0);
        @(posedge core_clk);
        fourth_data_input <= 1'b1;
        pulse(4'h0, 4'h1);
        check("async load", route_out, 1'b1);
        pulse(4'h2, 4'h1);
        check("clear first", route_out, 1'b0);
        // Synchronous load selector in up/down counter mode.
        axi_write(CFG_OFS, 32'h0000_0028);
        for (int v = 1; v >= 0; v--) begin
            @(posedge core_clk);
            data_in <= 3'h4;
            fourth_data_input <= v[0];
            tick(1);
            check("sync load", route_out, v[0]);
        end
        // Clearable counter: cascade-in acts as synchronous clear.
        axi_write(CFG_OFS, 32'h0000_002c);
        for (int v = 0; v <= 1; v++) begin
            @(posedge core_clk);
            data_in <= 3'h2;
            next_cascade <= v[0];
            tick(3);
            check("sync clear", route_out, !v[0]);
        end
        // Arithmetic: lower table half gives the sum, upper half the carry.
        axi_write(LUT_OFS, 32'h0000_ff00);
        axi_write(CFG_OFS, 32'h0000_0004);
        tick(1);
        check("arith", {local_out, carry_out}, 2'b01);
        // Emulated bus: none driving reads high, contention reads low.
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {tbus_oe, tbus_data} <= bus_case[i][8:1];
            tick(1);
            check("bus level", tbus_out, bus_case[i][0]);
        end
        final_report();
    end
endmodule
